// *** pdm_pkg.sv ***
// Constants for the port data multiplexer routing block.
// Assumes a byte-addressed register port with 32-bit words.
package pdm_pkg;
   // ----------------------------------------
   // Register byte addresses
   // ----------------------------------------
   localparam logic [7:0] ADR_CTRL  = 8'h00;
   localparam logic [7:0] ADR_DIR   = 8'h04;
   localparam logic [7:0] ADR_XSYS  = 8'h08;
   localparam logic [7:0] ADR_XTX   = 8'h0C;
   localparam logic [7:0] ADR_PU    = 8'h10;
   localparam logic [7:0] ADR_PD    = 8'h14;
   localparam logic [7:0] ADR_DETEN = 8'h18;
   localparam logic [7:0] ADR_ISTAT = 8'h1C;
   localparam logic [7:0] ADR_IMASK = 8'h20;
   localparam logic [7:0] ADR_STAT  = 8'h24;
   // ----------------------------------------
   // Control register fields
   // ----------------------------------------
   localparam int CT_PAIR_LSB = 0;
   localparam int CT_SBU_LSB  = 4;
   localparam int CT_LSXPASS  = 8;
   localparam int CT_UEN_LSB  = 9;
   localparam int CT_BUFEN    = 12;
   localparam int CT_W        = 13;
   localparam logic [12:0] CTRL_RST = 13'h1000;
   // ----------------------------------------
   // Pair and sideband source codes
   // ----------------------------------------
   localparam logic [3:0] SRC_NONE  = 4'h0;
   localparam logic [3:0] SRC_ROOT  = 4'h1;
   localparam logic [3:0] SRC_EP    = 4'h2;
   localparam logic [3:0] SRC_SWD   = 4'h3;
   localparam logic [3:0] SRC_DBG_A = 4'h4;
   localparam logic [3:0] SRC_DBG_B = 4'h5;
   localparam logic [3:0] SRC_AUX   = 4'h6;
   localparam logic [3:0] SRC_CORE  = 4'h7;
   localparam logic [2:0] SB_NONE   = 3'h0;
   localparam logic [2:0] SB_LSX    = 3'h5;
   localparam logic [2:0] SB_CORE   = 3'h6;
   // ----------------------------------------
   // Pin indices and crossbar
   // ----------------------------------------
   localparam int PIN_TDP = 0;
   localparam int PIN_TDM = 1;
   localparam int PIN_BDP = 2;
   localparam int PIN_BDM = 3;
   localparam int PIN_SBA = 4;
   localparam int PIN_SBB = 5;
   localparam int SYS_URX = 0;
   localparam int SYS_UTX = 1;
   localparam int SYS_LP2R = 2;
   localparam int SYS_LR2P = 3;
   localparam int XB_NODES = 9;
   localparam logic [5:0]  DIR_RST  = 6'h02;
   localparam logic [23:0] XSYS_RST = 24'hFFFF0F;
   localparam logic [11:0] XTX_RST  = 12'hFFF;
endpackage : pdm_pkg

// *** pdm_route.sv ***
// Routing control of the port data multiplexer: pair, sideband,
// crossbar, pulls, clamps and transition detectors.
// Assumes pin inputs synchronous to clk and a plain register port.
`timescale 1ns/1ns
module pdm_route
   import pdm_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // Register port
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [31:0] rdata,
   // Detected cable orientation, high when flipped
   input  wire logic        cable_flip,
   // Port pins (top D+, top D-, bottom D+, bottom D-, sideband a, b)
   input  wire logic [5:0]  port_in,
   output logic      [5:0]  port_out,
   output logic      [5:0]  port_oe,
   // Crossbar system pins (uart rx, uart tx, aux serial p2s, s2p, gpio0, gpio1)
   input  wire logic [5:0]  sys_in,
   output logic      [5:0]  sys_out,
   output logic      [5:0]  sys_oe,
   // Analog switch controls
   output logic      [3:0]  top_src,
   output logic      [3:0]  bot_src,
   output logic      [2:0]  sbu_src,
   output logic             sbu_swap,
   output logic             lsx_pass,
   output logic      [5:0]  pull_up,
   output logic      [5:0]  pull_dn,
   output logic      [5:0]  clamp_en,
   // Interrupt
   output logic             irq
);
   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [CT_W-1:0] ctrl;
   logic [5:0]      dir;
   logic [23:0]     xsys;
   logic [11:0]     xtx;
   logic [5:0]      det_en;
   logic [5:0]      istat;
   logic [5:0]      imask;
   logic [5:0]      port_s;
   logic [5:0]      port_p;
   logic [5:0]      sys_s;
   logic            orient;
   logic [5:0]      ev;
   logic [5:0]      next_istat;
   logic [8:0]      nodes;
   logic [3:0]      pair_sel;
   logic [2:0]      sbu_sel;
   logic [2:0]      uen;
   logic            buf_en;
   logic            lsx_byp;
   logic            wr_ctrl;

   assign pair_sel = ctrl[CT_PAIR_LSB +: 4];
   assign sbu_sel  = ctrl[CT_SBU_LSB +: 3];
   assign uen      = ctrl[CT_UEN_LSB +: 3];
   assign buf_en   = ctrl[CT_BUFEN];
   assign lsx_byp  = ctrl[CT_LSXPASS];
   assign wr_ctrl  = wr && addr == ADR_CTRL;

   // ----------------------------------------
   // Crossbar source pick
   // ----------------------------------------
   function automatic logic pick(input logic [8:0] n, input logic [3:0] s);
      logic r;
      r = 1'b0;
      if (s < 4'(XB_NODES)) begin
         r = n[s];
      end
      return r;
   endfunction : pick

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl    <= CTRL_RST;
         dir     <= DIR_RST;
         xsys    <= XSYS_RST;
         xtx     <= XTX_RST;
         pull_up <= 6'h00;
         pull_dn <= 6'h00;
         det_en  <= 6'h00;
         imask   <= 6'h00;
      end else if (wr) begin
         unique case (addr)
            ADR_CTRL:  ctrl    <= wdata[CT_W-1:0];
            ADR_DIR:   dir     <= wdata[5:0];
            ADR_XSYS:  xsys    <= wdata[23:0];
            ADR_XTX:   xtx     <= wdata[11:0];
            ADR_PU:    pull_up <= wdata[5:0];
            ADR_PD:    pull_dn <= wdata[5:0];
            ADR_DETEN: det_en  <= wdata[5:0];
            ADR_IMASK: imask   <= wdata[5:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata <= 32'h0000_0000;
      end else begin
         rdata <= 32'h0000_0000;
         if (rd) begin
            unique case (addr)
               ADR_CTRL:  rdata <= {19'h0, ctrl};
               ADR_DIR:   rdata <= {26'h0, dir};
               ADR_XSYS:  rdata <= {8'h0, xsys};
               ADR_XTX:   rdata <= {20'h0, xtx};
               ADR_PU:    rdata <= {26'h0, pull_up};
               ADR_PD:    rdata <= {26'h0, pull_dn};
               ADR_DETEN: rdata <= {26'h0, det_en};
               ADR_ISTAT: rdata <= {26'h0, istat};
               ADR_IMASK: rdata <= {26'h0, imask};
               ADR_STAT:  rdata <= {19'h0, orient, sys_s, port_s};
               default:   rdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ----------------------------------------
   // Input sampling and orientation
   // ----------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         port_s <= 6'h00;
         port_p <= 6'h00;
         sys_s  <= 6'h00;
         orient <= 1'b0;
      end else begin
         port_s <= port_in;
         port_p <= port_s;
         sys_s  <= sys_in;
         orient <= cable_flip;
      end
   end

   // Core serial receive lines; channel 2 follows the sideband swap
   assign nodes = {orient ? port_s[PIN_SBA] : port_s[PIN_SBB],
                   port_s[PIN_BDM], port_s[PIN_TDM], sys_s};

   // ----------------------------------------
   // Transition detectors and interrupt
   // ----------------------------------------
   assign ev = det_en & (port_s ^ port_p);

   always_comb begin
      next_istat = istat;
      if (wr && addr == ADR_ISTAT) begin
         next_istat = istat & ~wdata[5:0];
      end
      next_istat = next_istat | ev;  // Set wins over clear
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         istat <= 6'h00;
         irq   <= 1'b0;
      end else begin
         istat <= next_istat;
         irq   <= |(istat & imask);
      end
   end

   // ----------------------------------------
   // Analog switch selection and clamps
   // ----------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         top_src  <= SRC_NONE;
         bot_src  <= SRC_NONE;
         sbu_src  <= SB_NONE;
         sbu_swap <= 1'b0;
         lsx_pass <= 1'b0;
         clamp_en <= 6'h00;
      end else begin
         // Core routes are tied to one pair each; others follow orientation
         top_src  <= (pair_sel == SRC_CORE || !orient) ? pair_sel : SRC_NONE;
         bot_src  <= (pair_sel == SRC_CORE || orient) ? pair_sel : SRC_NONE;
         sbu_src  <= sbu_sel;
         sbu_swap <= orient;
         lsx_pass <= lsx_byp && sbu_sel == SB_LSX;
         clamp_en[1:0] <= {2{(pair_sel == SRC_CORE || !orient) && pair_sel != SRC_NONE}};
         clamp_en[3:2] <= {2{(pair_sel == SRC_CORE || orient) && pair_sel != SRC_NONE}};
         clamp_en[5:4] <= {2{sbu_sel != SB_NONE}};
      end
   end

   // ----------------------------------------
   // Digital crossbar, system side
   // ----------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sys_out <= 6'h00;
         sys_oe  <= 6'h00;
      end else begin
         for (int i = 0; i < 6; i++) begin
            sys_out[i] <= pick(nodes, xsys[4*i +: 4]);
            sys_oe[i]  <= dir[i] && buf_en
                          && !(lsx_byp && (i == SYS_LP2R || i == SYS_LR2P));
         end
      end
   end

   // ----------------------------------------
   // Digital crossbar, port side transmit
   // ----------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         port_out <= 6'h00;
         port_oe  <= 6'h00;
      end else begin
         port_out <= 6'h00;
         port_oe  <= 6'h00;
         port_out[PIN_TDP] <= pick(nodes, xtx[3:0]);
         port_oe[PIN_TDP]  <= uen[0] && buf_en && pair_sel == SRC_CORE;
         port_out[PIN_BDP] <= pick(nodes, xtx[7:4]);
         port_oe[PIN_BDP]  <= uen[1] && buf_en && pair_sel == SRC_CORE;
         if (orient) begin
            port_out[PIN_SBB] <= pick(nodes, xtx[11:8]);
            port_oe[PIN_SBB]  <= uen[2] && buf_en && sbu_sel == SB_CORE;
         end else begin
            port_out[PIN_SBA] <= pick(nodes, xtx[11:8]);
            port_oe[PIN_SBA]  <= uen[2] && buf_en && sbu_sel == SB_CORE;
         end
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence s_edge_seen;
      |ev;
   endsequence

   a_edge_sets_flag: assert property (s_edge_seen |=> (istat & $past(ev)) == $past(ev))
      else $error("Transition did not set its status bit");
   a_det_off_quiet: assert property (det_en == 6'h00 && istat == 6'h00 && !wr |=> istat == 6'h00)
      else $error("Disabled detector raised a status bit");
   a_irq_follows: assert property (|(istat & imask) |=> irq)
      else $error("Unmasked status did not raise interrupt");
   a_pair_one_side: assert property (pair_sel != SRC_CORE ##1 1 |-> top_src == SRC_NONE || bot_src == SRC_NONE)
      else $error("Non-core source on both pairs");
   a_swap_together: assert property (sbu_swap && top_src != SRC_CORE |-> top_src == SRC_NONE)
      else $error("Pair and sideband orientation disagree");
   a_bypass_copy: assert property (xsys[7:4] == 4'h0 |=> sys_out[SYS_UTX] == $past(sys_s[SYS_URX]))
      else $error("Serial bypass did not copy receive");
   a_tristate_off: assert property (!buf_en |=> sys_oe == 6'h00 && port_oe == 6'h00)
      else $error("Buffers drove while tri-stated");
   a_lsx_plain: assert property (lsx_byp |=> !sys_oe[SYS_LP2R] && !sys_oe[SYS_LR2P])
      else $error("Bypassed path still buffered");
   a_clamp_closed: assert property (clamp_en[1:0] == {2{top_src != SRC_NONE}})
      else $error("Top clamp not tied to closed path");
   a_dir_gates_out: assert property (!dir[SYS_UTX] |=> !sys_oe[SYS_UTX])
      else $error("Input pin was driven");
   a_sample_delay: assert property (##1 1 |-> port_s == $past(port_in))
      else $error("Port input not sampled on core clock");

   // ----------------------------------------
   // Routing and register assertions
   // ----------------------------------------
   sequence s_flipped;
      pair_sel != SRC_CORE && orient;
   endsequence

   sequence s_upright;
      pair_sel != SRC_CORE && !orient;
   endsequence

   a_top_follows: assert property (s_upright |=> top_src == $past(pair_sel))
      else $error("Top pair missed its source");

   a_bot_follows: assert property (s_flipped |=> bot_src == $past(pair_sel))
      else $error("Bottom pair missed its source");

   a_top_idle_flip: assert property (s_flipped |=> top_src == SRC_NONE)
      else $error("Top pair closed while flipped");

   a_bot_idle_up: assert property (s_upright |=> bot_src == SRC_NONE)
      else $error("Bottom pair closed while upright");

   a_core_both_pairs: assert property (pair_sel == SRC_CORE |=> top_src == SRC_CORE
                                       && bot_src == SRC_CORE)
      else $error("Core routes not on their fixed pairs");

   a_sbu_swap_orient: assert property (##1 1 |-> sbu_swap == $past(orient))
      else $error("Sideband swap does not follow orientation");

   a_sbu_one_drive: assert property (!(port_oe[PIN_SBA] && port_oe[PIN_SBB]))
      else $error("Both sideband pins driven");

   a_sbu_tx_up: assert property (!orient |=> !port_oe[PIN_SBB])
      else $error("Sideband b driven while upright");

   a_sbu_tx_flip: assert property (orient |=> !port_oe[PIN_SBA])
      else $error("Sideband a driven while flipped");

   a_sbu_src_copy: assert property (##1 1 |-> sbu_src == $past(sbu_sel))
      else $error("Sideband source not applied");

   a_ctrl_write: assert property (wr && addr == ADR_CTRL |=> ctrl == $past(wdata[CT_W-1:0]))
      else $error("Control write lost");

   a_orient_sample: assert property (##1 1 |-> orient == $past(cable_flip))
      else $error("Orientation not registered");

   a_sys_sample: assert property (##1 1 |-> sys_s == $past(sys_in))
      else $error("System input not sampled on core clock");

   a_sbu_clamp: assert property (##1 1 |-> clamp_en[5:4] == {2{$past(sbu_sel) != SB_NONE}})
      else $error("Sideband clamp not tied to closed path");

   a_bot_clamp: assert property (clamp_en[3:2] == {2{bot_src != SRC_NONE}})
      else $error("Bottom clamp not tied to closed path");

   a_irq_masked: assert property ((istat & imask) == 6'h00 |=> !irq)
      else $error("Interrupt raised with nothing unmasked");

   a_flag_sticky: assert property (!(wr && addr == ADR_ISTAT)
                                   |=> (istat & $past(istat)) == $past(istat))
      else $error("Status bit lost without a clear");

   a_flag_clear: assert property (wr && addr == ADR_ISTAT && ev == 6'h00
                                  |=> (istat & $past(wdata[5:0])) == 6'h00)
      else $error("Status bit not cleared by a one");

   a_pull_up_wr: assert property (wr && addr == ADR_PU |=> pull_up == $past(wdata[5:0]))
      else $error("Pull-up write lost");

   a_pull_dn_wr: assert property (wr && addr == ADR_PD |=> pull_dn == $past(wdata[5:0]))
      else $error("Pull-down write lost");

   a_det_wr: assert property (wr && addr == ADR_DETEN |=> det_en == $past(wdata[5:0]))
      else $error("Detector enable write lost");

   a_dir_wr: assert property (wr && addr == ADR_DIR |=> dir == $past(wdata[5:0]))
      else $error("Direction write lost");

   a_xsys_wr: assert property (wr && addr == ADR_XSYS |=> xsys == $past(wdata[23:0]))
      else $error("Crossbar write lost");

   a_xtx_wr: assert property (wr && addr == ADR_XTX |=> xtx == $past(wdata[11:0]))
      else $error("Transmit crossbar write lost");

   a_lsx_pass_set: assert property (##1 1 |-> lsx_pass == $past(lsx_byp && sbu_sel == SB_LSX))
      else $error("Aux serial plain switch not applied");

   a_rx_pins_quiet: assert property (!port_oe[PIN_TDM] && !port_oe[PIN_BDM])
      else $error("Receive-only pair pin driven");

endmodule : pdm_route

// *** pdm_cable_model.sv ***
// Cable partner model on the six port pins.
// Assumes block outputs are registered on the core clock.
`timescale 1ns/1ns
module pdm_cable_model
   import pdm_pkg::*;
(
   // Block side
   input  wire logic [5:0] port_out,
   input  wire logic [5:0] port_oe,
   input  wire logic [5:0] pull_up,
   input  wire logic [5:0] pull_dn,
   // Partner drive
   input  wire logic [5:0] far_val,
   input  wire logic [5:0] far_oe,
   // Resolved pin levels
   output logic      [5:0] pin_lvl
);
   // Released pin with no pull shows the inverse of the partner's far_val
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         if (port_oe[i])
            pin_lvl[i] = port_out[i];
         else if (far_oe[i])
            pin_lvl[i] = far_val[i];
         else if (pull_up[i])
            pin_lvl[i] = 1'b1;
         else if (pull_dn[i])
            pin_lvl[i] = 1'b0;
         else
            pin_lvl[i] = ~far_val[i];
      end
   end
endmodule : pdm_cable_model

// *** test_port_data_mux_routing.sv ***
// Testbench for the port data multiplexer routing block.
// Assumes the cable partner model and the design package.
`timescale 1ns/1ns
module test_port_data_mux_routing
   import pdm_pkg::*;
;
   logic        clk, reset_n, wr, rd, cable_flip, sbu_swap, lsx_pass, irq;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata, v;
   logic [5:0]  port_in, port_out, port_oe, sys_in, sys_out, sys_oe;
   logic [5:0]  pull_up, pull_dn, clamp_en, far_val, far_oe;
   logic [3:0]  top_src, bot_src;
   logic [2:0]  sbu_src;
   int          err_total, num_checks;

   pdm_route dut (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .cable_flip(cable_flip),
      .port_in(port_in), .port_out(port_out), .port_oe(port_oe),
      .sys_in(sys_in), .sys_out(sys_out), .sys_oe(sys_oe),
      .top_src(top_src), .bot_src(bot_src), .sbu_src(sbu_src),
      .sbu_swap(sbu_swap), .lsx_pass(lsx_pass), .pull_up(pull_up),
      .pull_dn(pull_dn), .clamp_en(clamp_en), .irq(irq));

   pdm_cable_model partner (.port_out(port_out), .port_oe(port_oe),
      .pull_up(pull_up), .pull_dn(pull_dn), .far_val(far_val),
      .far_oe(far_oe), .pin_lvl(port_in));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task finish_test;
      $display("checks=%0d mismatches=%0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : finish_test

   task wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   task rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask : rd_chk

   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   task wait_irq;
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 20) begin
         cyc(1);
         n++;
      end
      if (irq !== 1'b1) begin
         err_total++;
         finish_test();
      end
   endtask : wait_irq

   initial begin
      {reset_n, wr, rd, cable_flip} = 4'h0;
      addr    = 8'h00;
      wdata   = 32'h0;
      sys_in  = 6'h00;
      far_val = 6'h00;
      far_oe  = 6'h3F;
      err_total  = 0;
      num_checks = 0;
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      // Reset values and an unmapped place
      rd_chk(ADR_CTRL, {19'h0, CTRL_RST});
      rd_chk(ADR_DIR, {26'h0, DIR_RST});
      rd_chk(ADR_XSYS, {8'h0, XSYS_RST});
      rd_chk(ADR_XTX, {20'h0, XTX_RST});
      wr_reg(8'h28, 32'hFFFF_FFFF);
      rd_chk(8'h28, 32'h0);
      // Power-up serial bypass
      @(posedge clk);
      sys_in <= 6'h01;
      cyc(3);
      chk({30'h0, sys_oe[1], sys_out[1]}, 32'h3);
      @(posedge clk);
      sys_in <= 6'h00;
      cyc(3);
      chk({30'h0, sys_oe[1], sys_out[1]}, 32'h2);
      // Root pair, aux serial on sideband, both orientations
      wr_reg(ADR_CTRL, 32'h0000_1051);
      cyc(3);
      chk({top_src, bot_src, sbu_src, sbu_swap}, {SRC_ROOT, SRC_NONE, SB_LSX, 1'b0});
      chk({26'h0, clamp_en}, 32'h33);
      @(posedge clk);
      cable_flip <= 1'b1;
      cyc(3);
      chk({top_src, bot_src, sbu_swap}, {SRC_NONE, SRC_ROOT, 1'b1});
      chk({26'h0, clamp_en}, 32'h3C);
      rd_chk(ADR_STAT, 32'h0000_1000);
      @(posedge clk);
      cable_flip <= 1'b0;
      repeat (4) begin
         cyc(1);
         chk({31'h0, top_src == SRC_NONE}, {31'h0, sbu_swap});
      end
      chk({top_src, sbu_swap}, {SRC_ROOT, 1'b0});
      // Aux serial bypass, then buffers off
      wr_reg(ADR_CTRL, 32'h0000_1151);
      cyc(3);
      chk({29'h0, lsx_pass, sys_oe[3:2]}, 32'h4);
      wr_reg(ADR_CTRL, 32'h0);
      cyc(3);
      chk({20'h0, sys_oe, port_oe}, 32'h0);
      chk({26'h0, clamp_en}, 32'h0);
      // Core serial route 0 transmit on top D+
      wr_reg(ADR_CTRL, 32'h0000_1207);
      wr_reg(ADR_XTX, 32'h0);
      @(posedge clk);
      sys_in <= 6'h01;
      cyc(3);
      chk({30'h0, port_oe[0], port_out[0]}, 32'h3);
      chk({top_src, bot_src}, {SRC_CORE, SRC_CORE});
      chk({26'h0, clamp_en}, 32'h0F);
      @(posedge clk);
      sys_in <= 6'h00;
      cyc(3);
      chk({30'h0, port_oe[0], port_out[0]}, 32'h2);
      wr_reg(ADR_CTRL, 32'h0);
      // Pulls
      wr_reg(ADR_PU, 32'h2A);
      wr_reg(ADR_PD, 32'h15);
      cyc(3);
      chk({20'h0, pull_up, pull_dn}, 32'hA95);
      wr_reg(ADR_PU, 32'h0);
      wr_reg(ADR_PD, 32'h0);
      // Transition detector, mask and clear
      wr_reg(ADR_DETEN, 32'h02);
      wr_reg(ADR_IMASK, 32'h02);
      wr_reg(ADR_ISTAT, 32'h3F);
      cyc(2);
      chk({31'h0, irq}, 32'h0);
      @(posedge clk);
      far_val <= 6'h02;
      wait_irq();
      rd_chk(ADR_ISTAT, 32'h02);
      wr_reg(ADR_IMASK, 32'h0);
      cyc(2);
      chk({31'h0, irq}, 32'h0);
      wr_reg(ADR_ISTAT, 32'h02);
      rd_chk(ADR_ISTAT, 32'h0);
      wr_reg(ADR_IMASK, 32'h02);
      wr_reg(ADR_DETEN, 32'h0);
      @(posedge clk);
      far_val <= 6'h00;
      cyc(6);
      chk({31'h0, irq}, 32'h0);
      rd_chk(ADR_ISTAT, 32'h0);
      finish_test();
   end
endmodule : test_port_data_mux_routing
